// ===== dir_entry_pkg.sv
// Package: directory entry layout, fill values and carrier types
package dir_entry_pkg;
   // ----------------------------------------
   // Entry layout (byte offsets)
   // ----------------------------------------
   localparam logic [6:0] ENT_BYTES = 7'd112;
   localparam logic [6:0] OFS_START = 7'd56;
   localparam logic [6:0] OFS_COUNT = 7'd64;
   localparam logic [6:0] OFS_SIZE  = 7'd72;
   localparam logic [6:0] OFS_DATE  = 7'd80;
   localparam logic [6:0] OFS_CTIME = 7'd88;
   localparam logic [6:0] OFS_TYPE  = 7'd96;
   localparam logic [6:0] OFS_RSVD  = 7'd97;
   localparam logic [6:0] OFS_CLOSE = 7'd104;
   localparam int         NAME_CHARS = 55;
   localparam int         MAX_ENT   = 4;
   localparam int         HUND_POS  = 6;
   // ----------------------------------------
   // Fill values and codes
   // ----------------------------------------
   localparam logic [7:0] FILL_FF     = 8'hff;
   localparam logic [7:0] FILL_00     = 8'h00;
   localparam logic [7:0] ASCII_ZERO  = 8'h30;
   localparam logic [7:0] ASCII_SPACE = 8'h20;
   localparam logic [7:0] TYPE_UTC    = 8'h00;
   localparam logic [7:0] TYPE_LOCAL  = 8'h01;
   localparam logic [31:0] ADDR_RST   = 32'h0;
   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic [NAME_CHARS*8-1:0] name;
      logic [63:0]             start_block_address;
      logic [63:0]             reserved_block_count;
      logic [63:0]             file_byte_length;
      logic [31:0]             date_bcd;
      logic                    date_ok;
      logic [31:0]             ctime_bcd;
      logic                    ctime_ok;
      logic                    chund_ok;
      logic [31:0]             xtime_bcd;
      logic                    xtime_ok;
      logic                    xhund_ok;
      logic [7:0]              time_type;
   } entry_req_type;
   typedef struct packed {
      logic dup;
      logic overlap;
      logic too_big;
      logic bad_type;
      logic no_room;
   } err_type;
   typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_EMIT} fsm_type;
endpackage

// ===== directory_entry_formatter.sv
// Directory entry builder, checker and byte streamer
// Function
// - Name field 56 bytes ASCII; unused entry name bytes all FFh.
// - Start address 8 bytes zero based; unused entry fills FFh.
// - Block count one based, includes start block; unused entry fills 00h.
// - Byte length must not exceed block count times block size.
// - Create date ASCII DDMMYYYY; all 30h when unavailable.
// - Create time ASCII HHMMSSss, 24-hour clock, no separators.
// - Whole time unavailable gives 20h; missing hundredths give 30h digits.
// - Time type 00h UTC, 01h local; higher codes never produced.
// - Seven reserved bytes after time type always 00h.
// - Close time uses create time layout, records file close.
// - Entry whose name matches an existing entry is rejected.
// - Block ranges of two entries never overlap; overlapping request refused.
// - Entries and fields written at contiguous logical addresses.
// - Binary fields sent least significant byte first, lowest address first.
// - Each file one 112-byte entry; entry count tracks files held.
// - Name left justified, terminated by 00h; usable length field minus one.
module directory_entry_formatter
(
   input  wire logic                          REF_CLK_I,
   input  wire logic                          RST_N_I,
   input  wire logic                          REQ_ADD_I,
   input  wire logic                          REQ_PAD_I,
   input  wire dir_entry_pkg::entry_req_type  REQ_I,
   input  wire logic                          DIR_CLEAR_I,
   input  wire logic [31:0]                   DIR_BASE_I,
   input  wire logic [31:0]                   BLOCK_SIZE_I,
   input  wire logic                          OUT_READY_I,
   output logic                               OUT_VALID_O,
   output logic [7:0]                         OUT_BYTE_O,
   output logic [31:0]                        OUT_ADDR_O,
   output logic                               OUT_LAST_O,
   output logic                               BUSY_O,
   output logic                               DONE_O,
   output dir_entry_pkg::err_type             ERR_O,
   output logic [15:0]                        ENTRY_COUNT_O
);
   import dir_entry_pkg::*;

   typedef struct packed {
      fsm_type                             st;
      entry_req_type                       req;
      logic                                pad;
      logic [6:0]                          ofs;
      logic [31:0]                         acnt;
      logic                                vld;
      logic [7:0]                          obyte;
      logic [31:0]                         oaddr;
      logic                                last;
      logic [6:0]                          oofs;
      logic                                opad;
      logic                                busy;
      logic                                done;
      err_type                             err;
      logic [15:0]                         cnt;
      logic [MAX_ENT-1:0]                  tv;
      logic [MAX_ENT-1:0][NAME_CHARS*8-1:0] tn;
      logic [MAX_ENT-1:0][63:0]            ts;
      logic [MAX_ENT-1:0][63:0]            tc;
   } state_type;

   state_type  s_r;
   state_type  s_nxt;
   logic [1:0] rst_sync_r;
   logic       rst_n;
   logic       dup;
   logic       ovl;
   logic       big;
   logic [MAX_ENT-1:0] slot;

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   // Two stages; only the second one is read
   always_ff @(posedge REF_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         rst_sync_r <= 2'b00;
      else
         rst_sync_r <= {rst_sync_r[0], 1'b1};
   end
   assign rst_n = rst_sync_r[1];

   // ----------------------------------------
   // Field formatting
   // ----------------------------------------
   // BCD digit to ASCII
   function automatic logic [7:0] asc(input logic [3:0] d);
      return ASCII_ZERO | {4'h0, d};
   endfunction

   // Time byte k of HHMMSSss, fills for missing parts
   function automatic logic [7:0] tbyte(input logic [31:0] t, input logic ok,
                                         input logic hok, input logic [2:0] k);
      if (!ok)
         return ASCII_SPACE;
      if (!hok && int'(k) >= HUND_POS)
         return ASCII_ZERO;
      return asc(t[(7 - int'(k)) * 4 +: 4]);
   endfunction

   // Byte at offset o of an entry; p marks an unused entry
   function automatic logic [7:0] byte_at(input entry_req_type r, input logic p,
                                           input logic [6:0] o);
      logic [2:0] k;
      k = o[2:0];
      if (o < OFS_START)
      begin
         if (p)
            return FILL_FF;
         if (o == OFS_START - 7'd1)
            return FILL_00;
         return r.name[int'(o) * 8 +: 8];
      end
      if (o < OFS_COUNT)                                       // LSB first
         return p ? FILL_FF : r.start_block_address[int'(k) * 8 +: 8];
      if (o < OFS_SIZE)
         return p ? FILL_00 : r.reserved_block_count[int'(k) * 8 +: 8];
      if (o < OFS_DATE)
         return p ? FILL_00 : r.file_byte_length[int'(k) * 8 +: 8];
      if (o < OFS_CTIME)
      begin
         if (p || !r.date_ok)
            return ASCII_ZERO;
         return asc(r.date_bcd[(7 - int'(k)) * 4 +: 4]);
      end
      if (o < OFS_TYPE)
         return p ? ASCII_SPACE : tbyte(r.ctime_bcd, r.ctime_ok, r.chund_ok, k);
      if (o == OFS_TYPE)
         return p ? TYPE_UTC : r.time_type;
      if (o < OFS_CLOSE)
         return FILL_00;
      return p ? ASCII_SPACE : tbyte(r.xtime_bcd, r.xtime_ok, r.xhund_ok, k);
   endfunction

   // ----------------------------------------
   // Directory checks
   // ----------------------------------------
   // Full compare against every held entry; cheap at this depth
   always_comb
   begin
      logic [64:0] a_end;
      logic [64:0] b_end;
      logic [95:0] cap;
      a_end = '0;
      b_end = '0;
      cap   = '0;
      dup  = 1'b0;
      ovl  = 1'b0;
      slot = '0;
      for (int i = 0; i < MAX_ENT; i++)
      begin
         a_end = {1'b0, s_r.req.start_block_address} + {1'b0, s_r.req.reserved_block_count};
         b_end = {1'b0, s_r.ts[i]} + {1'b0, s_r.tc[i]};
         if (s_r.tv[i] && s_r.tn[i] == s_r.req.name)
            dup = 1'b1;
         if (s_r.tv[i] && {1'b0, s_r.req.start_block_address} < b_end
             && {1'b0, s_r.ts[i]} < a_end)
            ovl = 1'b1;
         if (!s_r.tv[i] && slot == '0)
            slot[i] = 1'b1;
      end
      cap = 96'(s_r.req.reserved_block_count) * 96'(BLOCK_SIZE_I);
      big = 96'(s_r.req.file_byte_length) > cap;
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      s_nxt      = s_r;
      s_nxt.done = 1'b0;
      if (OUT_READY_I)
         s_nxt.vld = 1'b0;
      unique case (s_r.st)
         ST_IDLE:
         begin
            if (REQ_ADD_I)
            begin
               s_nxt.req = REQ_I;
               s_nxt.pad = 1'b0;
               s_nxt.err = '0;
               s_nxt.st  = ST_CHECK;
            end
            else if (REQ_PAD_I)
            begin
               s_nxt.pad = 1'b1;
               s_nxt.err = '0;
               s_nxt.ofs = '0;
               s_nxt.st  = ST_EMIT;
            end
            else if (DIR_CLEAR_I && !s_r.vld)
            begin
               s_nxt.tv   = '0;
               s_nxt.cnt  = '0;
               s_nxt.acnt = DIR_BASE_I;
            end
         end
         ST_CHECK:
         begin
            s_nxt.err.dup      = dup;
            s_nxt.err.overlap  = ovl;
            s_nxt.err.too_big  = big;
            s_nxt.err.bad_type = s_r.req.time_type > TYPE_LOCAL;
            s_nxt.err.no_room  = (slot == '0) || (s_r.req.reserved_block_count == '0);
            if (dup || ovl || big || s_r.req.time_type > TYPE_LOCAL || slot == '0
                || s_r.req.reserved_block_count == '0)
            begin
               s_nxt.done = 1'b1;
               s_nxt.st   = ST_IDLE;
            end
            else
            begin
               for (int i = 0; i < MAX_ENT; i++)
               begin
                  if (slot[i])
                  begin
                     s_nxt.tv[i] = 1'b1;
                     s_nxt.tn[i] = s_r.req.name;
                     s_nxt.ts[i] = s_r.req.start_block_address;
                     s_nxt.tc[i] = s_r.req.reserved_block_count;
                  end
               end
               s_nxt.cnt = s_r.cnt + 16'h1;
               s_nxt.ofs = '0;
               s_nxt.st  = ST_EMIT;
            end
         end
         ST_EMIT:
         begin
            // Output stage advances only when empty or being drained
            if (!s_r.vld || OUT_READY_I)
            begin
               s_nxt.vld   = 1'b1;
               s_nxt.obyte = byte_at(s_r.req, s_r.pad, s_r.ofs);
               s_nxt.oaddr = s_r.acnt;
               s_nxt.oofs  = s_r.ofs;
               s_nxt.opad  = s_r.pad;
               s_nxt.last  = s_r.ofs == ENT_BYTES - 7'd1;
               s_nxt.acnt  = s_r.acnt + 32'h1;
               s_nxt.ofs   = s_r.ofs + 7'd1;
               if (s_r.ofs == ENT_BYTES - 7'd1)
               begin
                  s_nxt.done = 1'b1;
                  s_nxt.st   = ST_IDLE;
               end
            end
         end
      endcase
      s_nxt.busy = (s_nxt.st != ST_IDLE) || s_nxt.vld;
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge REF_CLK_I or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_r      <= '0;
         s_r.st   <= ST_IDLE;
         s_r.acnt <= ADDR_RST;
      end
      else
         s_r <= s_nxt;
   end

   assign OUT_VALID_O   = s_r.vld;
   assign OUT_BYTE_O    = s_r.obyte;
   assign OUT_ADDR_O    = s_r.oaddr;
   assign OUT_LAST_O    = s_r.last;
   assign BUSY_O        = s_r.busy;
   assign DONE_O        = s_r.done;
   assign ERR_O         = s_r.err;
   assign ENTRY_COUNT_O = s_r.cnt;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!rst_n);

   a_pad_name_ff: assert property (OUT_VALID_O && s_r.opad && s_r.oofs < OFS_START
      |-> OUT_BYTE_O == FILL_FF) else $error("unused name byte not FFh");
   a_pad_start_ff: assert property (OUT_VALID_O && s_r.opad
      && s_r.oofs >= OFS_START && s_r.oofs < OFS_COUNT |-> OUT_BYTE_O == FILL_FF)
      else $error("unused start address not FFh");
   a_pad_count_zero: assert property (OUT_VALID_O && s_r.opad
      && s_r.oofs >= OFS_COUNT && s_r.oofs < OFS_SIZE |-> OUT_BYTE_O == FILL_00)
      else $error("unused block count not 00h");
   a_rsvd_zero: assert property (OUT_VALID_O && s_r.oofs >= OFS_RSVD
      && s_r.oofs < OFS_CLOSE |-> OUT_BYTE_O == FILL_00) else $error("reserved not zero");
   a_type_legal: assert property (OUT_VALID_O && s_r.oofs == OFS_TYPE
      |-> OUT_BYTE_O <= TYPE_LOCAL) else $error("undefined time type sent");
   a_name_term: assert property (OUT_VALID_O && !s_r.opad
      && s_r.oofs == OFS_START - 7'd1 |-> OUT_BYTE_O == FILL_00)
      else $error("name terminator missing");
   a_addr_step: assert property (OUT_VALID_O && OUT_READY_I ##1 OUT_VALID_O
      |-> OUT_ADDR_O == $past(OUT_ADDR_O) + 32'h1) else $error("address gap");
   a_dup_reject: assert property (s_r.st == ST_CHECK && dup
      |=> ERR_O.dup && DONE_O && $stable(ENTRY_COUNT_O)) else $error("duplicate accepted");
   a_ovl_reject: assert property (s_r.st == ST_CHECK && ovl
      |=> ERR_O.overlap && !OUT_VALID_O [*2]) else $error("overlap accepted");
   a_size_reject: assert property (s_r.st == ST_CHECK && big
      |=> ERR_O.too_big && $stable(ENTRY_COUNT_O)) else $error("oversize accepted");
   a_count_step: assert property (s_r.st == ST_CHECK && ERR_O == '0 ##1 !(|ERR_O)
      && $past(s_r.st) == ST_CHECK |-> ENTRY_COUNT_O == $past(ENTRY_COUNT_O) + 16'h1)
      else $error("entry count not stepped");

   c_add_ok: cover property (s_r.st == ST_CHECK ##1 s_r.st == ST_EMIT);
   c_dup: cover property (s_r.st == ST_CHECK && dup);
   c_pad_last: cover property (OUT_VALID_O && OUT_LAST_O && s_r.opad);
   c_stall: cover property (OUT_VALID_O && !OUT_READY_I ##1 OUT_VALID_O);
endmodule

// ===== byte_sink.sv
// Storage-side byte sink that records every accepted byte and can stall
module byte_sink
(
   input  wire logic        clk_i,
   input  wire logic        valid_i,
   input  wire logic [7:0]  byte_i,
   input  wire logic [31:0] addr_i,
   input  wire logic        last_i,
   input  wire logic        stall_i,
   output logic             ready_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0]  got_q[$];
   logic [31:0] adr_q[$];
   logic        lst_q[$];
   initial ready_o = 1'b0;
   // Capture on handshake; ready moves just after the edge, random while stalling
   always @(posedge clk_i)
   begin
      if (valid_i && ready_o)
      begin
         got_q.push_back(byte_i);
         adr_q.push_back(addr_i);
         lst_q.push_back(last_i);
      end
      ready_o <= #1 stall_i ? 1'($urandom % 2) : 1'b1;
   end
endmodule

// ===== testbench.sv
// Self-checking bench for the directory entry formatter
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import dir_entry_pkg::*;
   logic          clk = 1'b0, rst_n = 1'b0, add = 1'b0, pad = 1'b0, clr = 1'b0, stall = 1'b0;
   logic          rdy, vld, last, busy, done;
   logic [7:0]    ob;
   logic [31:0]   oa, naddr = '0, base = 32'h0000_4000, bsz = 32'd512;
   logic [15:0]   cnt;
   err_type       err;
   entry_req_type req = '0, nx = '0;
   int            n_mismatch = 0, compares = 0, nheld = 0;
   logic [63:0]   hs[$], hc[$];
   logic [NAME_CHARS*8-1:0] hn[$];
   logic [7:0]    eb[112];
   always #10 clk = ~clk;
   directory_entry_formatter DUT (.REF_CLK_I(clk), .RST_N_I(rst_n), .REQ_ADD_I(add),
      .REQ_PAD_I(pad), .REQ_I(req), .DIR_CLEAR_I(clr), .DIR_BASE_I(base),
      .BLOCK_SIZE_I(bsz), .OUT_READY_I(rdy), .OUT_VALID_O(vld), .OUT_BYTE_O(ob),
      .OUT_ADDR_O(oa), .OUT_LAST_O(last), .BUSY_O(busy), .DONE_O(done), .ERR_O(err),
      .ENTRY_COUNT_O(cnt));
   byte_sink sink (.clk_i(clk), .valid_i(vld), .byte_i(ob), .addr_i(oa), .last_i(last),
      .stall_i(stall), .ready_o(rdy));
   // ----------------------------------------
   // Reference model and compare tasks
   // ----------------------------------------
   task automatic chk(string what, logic [63:0] e, logic [63:0] g);
      compares++;
      if (e !== g)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic complete_run();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Whole time missing gives spaces, missing hundredths give zero digits
   function automatic logic [7:0] tbyte(logic [31:0] v, logic ok, logic hok, int j);
      return !ok ? 8'h20 : (j >= HUND_POS && !hok) ? 8'h30 : {4'h3, v[31-4*j -: 4]};
   endfunction
   function automatic logic [31:0] rbcd();
      logic [31:0] v;
      for (int j = 0; j < 8; j++)
         v[4*j +: 4] = 4'($urandom % 10);
      return v;
   endfunction
   // Random name of 1..55 characters, range in its own thousand-block slot
   task automatic mk(int k, logic [7:0] ty);
      int len;
      len = 1 + $urandom % NAME_CHARS;
      nx = '0;
      for (int i = 0; i < len; i++)
         nx.name[8*i +: 8] = 8'h41 + 8'($urandom % 26);
      nx.start_block_address = 64'(k * 1000 + $urandom % 100);
      nx.reserved_block_count = 64'(1 + $urandom % 50);
      nx.file_byte_length = 64'($urandom) % (nx.reserved_block_count * bsz + 1);
      nx.date_bcd = rbcd();
      nx.ctime_bcd = rbcd();
      nx.xtime_bcd = rbcd();
      {nx.date_ok, nx.ctime_ok, nx.chund_ok, nx.xtime_ok, nx.xhund_ok} = 5'($urandom);
      nx.time_type = ty;
   endtask
   task automatic build(logic is_pad);
      for (int i = 0; i < 112; i++)
         if (is_pad)
            eb[i] = i < 64 ? 8'hff : i < 80 ? 8'h00 : i < 88 ? 8'h30 : i < 96 ? 8'h20
                  : i < 104 ? 8'h00 : 8'h20;
         else
            eb[i] = i < 55 ? nx.name[8*i +: 8] : i < 56 ? 8'h00
                  : i < 64 ? nx.start_block_address[8*(i-56) +: 8]
                  : i < 72 ? nx.reserved_block_count[8*(i-64) +: 8]
                  : i < 80 ? nx.file_byte_length[8*(i-72) +: 8]
                  : i < 88 ? (nx.date_ok ? tbyte(nx.date_bcd, 1'b1, 1'b1, i-80) : 8'h30)
                  : i < 96 ? tbyte(nx.ctime_bcd, nx.ctime_ok, nx.chund_ok, i-88)
                  : i < 97 ? nx.time_type : i < 104 ? 8'h00
                  : tbyte(nx.xtime_bcd, nx.xtime_ok, nx.xhund_ok, i-104);
   endtask
   // One request: predict refusal, pulse, wait for completion, compare stream
   task automatic run(logic is_pad);
      logic [4:0] e;
      logic       dup, ovl;
      int         k;
      dup = 1'b0;
      ovl = 1'b0;
      for (k = 0; k < nheld; k++)
      begin
         dup |= hn[k] == nx.name;
         ovl |= nx.start_block_address < hs[k] + hc[k]
                && hs[k] < nx.start_block_address + nx.reserved_block_count;
      end
      e = is_pad ? 5'h00 : {dup, ovl, nx.file_byte_length > nx.reserved_block_count * bsz,
          nx.time_type > TYPE_LOCAL, nheld == MAX_ENT || nx.reserved_block_count == 0};
      build(is_pad);
      sink.got_q.delete();
      sink.adr_q.delete();
      sink.lst_q.delete();
      @(posedge clk);
      #1;
      req = nx;
      add = !is_pad;
      pad = is_pad;
      @(posedge clk);
      #1;
      add = 1'b0;
      pad = 1'b0;
      chk("busy", 1'b1, busy);
      k = 0;
      while (done !== 1'b1 && k < 600)
      begin
         @(negedge clk);
         k++;
      end
      chk("done", 1'b1, done);
      // A refused request answers one cycle after its check
      if (e != 0)
         chk("reject cycles", 64'd2, 64'(k));
      if (!is_pad)
         chk("err", 64'(e), 64'(err));
      while (busy !== 1'b0 && k < 900)
      begin
         @(negedge clk);
         k++;
      end
      chk("bytes", e == 0 ? 64'd112 : 64'd0, 64'(sink.got_q.size()));
      for (int i = 0; i < 112 && e == 0; i++)
      begin
         if (i < 80)
            chk("binary byte", eb[i], sink.got_q[i]);
         else
            chk("text byte", eb[i], sink.got_q[i]);
         chk("addr", naddr + 32'(i), sink.adr_q[i]);
         chk("last", 64'(i == 111), 64'(sink.lst_q[i]));
      end
      if (e == 0)
         naddr += 32'd112;
      if (e == 0 && !is_pad)
      begin
         hs.push_back(nx.start_block_address);
         hc.push_back(nx.reserved_block_count);
         hn.push_back(nx.name);
         nheld++;
      end
      chk("count", 64'(nheld), 64'(cnt));
   endtask
   // ----------------------------------------
   // Stimulus
   // ----------------------------------------
   initial
   begin
      void'($urandom(37));
      // Block size is drawn once from the fixed seed, between 512 and 65536
      bsz = 32'd512 << ($urandom % 8);
      repeat (20) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (3) @(posedge clk);
      run(1'b1);
      mk(0, TYPE_UTC);
      run(1'b0);
      mk(1, TYPE_LOCAL);
      stall = 1'b1;
      run(1'b0);
      stall = 1'b0;
      mk(2, TYPE_UTC);
      nx.name = hn[0];
      run(1'b0);
      mk(2, TYPE_UTC);
      nx.start_block_address = hs[1] + hc[1] - 1;
      run(1'b0);
      mk(2, TYPE_UTC);
      nx.file_byte_length = nx.reserved_block_count * bsz + 1;
      run(1'b0);
      mk(2, 8'h02);
      run(1'b0);
      mk(2, TYPE_UTC);
      nx.reserved_block_count = 0;
      nx.file_byte_length = 0;
      run(1'b0);
      // Last fill entry sits exactly on the size limit, which must pass
      for (int k = 2; k < 4; k++)
      begin
         mk(k, TYPE_LOCAL);
         if (k == 3)
            nx.file_byte_length = nx.reserved_block_count * bsz;
         run(1'b0);
      end
      mk(5, TYPE_UTC);
      run(1'b0);
      run(1'b1);
      // Clearing restarts the table and the address at the base
      @(posedge clk);
      #1 clr = 1'b1;
      repeat (3) @(posedge clk);
      #1 clr = 1'b0;
      naddr = base;
      nheld = 0;
      hs.delete();
      hc.delete();
      hn.delete();
      mk(0, TYPE_UTC);
      run(1'b0);
      complete_run();
   end
   // Watchdog far beyond the longest stalled sequence
   initial
   begin
      #400000;
      n_mismatch++;
      complete_run();
   end
endmodule
